/* logic/stn_lcd_pixel_pipeline.sv */
// Pixel path of a passive-matrix panel controller: unpack, level maps, duty dithering, shift out.
// Assumes words arrive from fetch logic on CLK; SHIFT_CLK and FRAME_START are panel-side pins.
//
// Function
// - 256-color pixel is 3/3/2 bit codes
// - Red bits 7:5, green 4:2, blue 1:0
// - Red code selects 4-bit red map field
// - Green code selects 4-bit green map field
// - Blue code selects one of four fields
// - 4096-color: 4 bits each, no map
// - Eight 4096 pixels pack into three words
// - Gray and color components pass through dithering
// - Level shown by on-frames in 16-frame period
// - Duty per level follows fixed fraction table
// - Dual scan: upper and lower halves together
// - Single 4-bit uses low lines only
// - Single 8-bit uses all eight lines
// - Color sends R, G, B bits consecutively
// - Mono words go out MSB first
// - Gray uses 2 or 4 bits per pixel
// - 4-level gray maps through blue fields
// - Mono bypasses maps and dithering
//
// The register offsets and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module stn_lcd_pixel_pipeline
   import stn_pixel_pkg::*;
(
   // Clock and reset
   input wire logic CLK,
   input wire logic NRST,
   // Register port
   input wire logic [7:0] REG_ADDR,
   input wire logic [31:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [31:0] REG_RDATA,
   // Video words: lane 0 upper half or single scan, lane 1 lower half
   input wire word_in_t [1:0] WORD_IN,
   output logic [1:0] WORD_READY,
   // Panel pins
   input wire logic SHIFT_CLK,
   input wire logic FRAME_START,
   output logic [7:0] PANEL_DATA_LINES
);

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   ctrl_t ctrl;
   logic [31:0] red_map_fields;
   logic [31:0] green_map_fields;
   logic [15:0] blue_map_fields;
   logic underrun;
   logic [3:0] frame_cnt;
   logic [1:0] sclk_sync;
   logic [1:0] fs_sync;
   logic sclk_prev;
   logic fs_prev;
   logic shift_edge;
   logic frame_edge;
   logic dual;
   logic [6:0] lane_w;
   logic enough;
   logic take;
   logic underrun_evt;
   logic [31:0] rd_mux;
   logic [63:0] acc [2];
   logic [6:0] cnt [2];
   logic lane_ready [2];
   logic [31:0] word_sw [2];
   unpack_t unp [2];

   // ------------------------------------------------------------
   // Dither duty unit and word unpacking
   // ------------------------------------------------------------
   // Carry form of num/den: on-frames are spread as evenly as the fraction allows.
   function automatic logic dith(input logic [3:0] lvl, input logic [3:0] f);
      logic [2:0] num;
      logic [2:0] den;
      logic [3:0] q;
      logic [6:0] prod;
      num = DUTY_NUM[lvl];
      den = DUTY_DEN[lvl];
      q = f % {1'b0, den};
      prod = {3'h0, q} * {4'h0, num};
      return ((prod % {4'h0, den}) + {4'h0, num}) >= {4'h0, den};
   endfunction

   function automatic unpack_t unpack(input logic [31:0] w, input pixel_mode_t mode,
                                      input logic [3:0] f);
      unpack_t u;
      logic [7:0] px;
      logic [1:0] code;
      u = '0;
      px = 8'h00;
      code = 2'h0;
      unique case (mode)
         MODE_MONO: begin
            u.bits = w;
            u.n = N_MONO;
         end
         MODE_GRAY4: begin
            for (int i = 0; i < 16; i++) begin
               code = w[31 - 2 * i -: 2];
               u.bits[31 - i] = dith(blue_map_fields[{code, 2'b00} +: 4], f);
            end
            u.n = N_GRAY4;
         end
         MODE_GRAY16, MODE_COLOR4096: begin
            // Nibbles already run R, G, B in order across the three words.
            for (int i = 0; i < 8; i++) begin
               u.bits[31 - i] = dith(w[31 - 4 * i -: 4], f);
            end
            u.n = N_NIBBLE;
         end
         MODE_COLOR256: begin
            for (int i = 0; i < 4; i++) begin
               px = w[31 - 8 * i -: 8];
               u.bits[31 - 3 * i] = dith(red_map_fields[{px[7:5], 2'b00} +: 4], f);
               u.bits[30 - 3 * i] = dith(green_map_fields[{px[4:2], 2'b00} +: 4], f);
               u.bits[29 - 3 * i] = dith(blue_map_fields[{px[1:0], 2'b00} +: 4], f);
            end
            u.n = N_COLOR256;
         end
         default: begin
            u = '0;
         end
      endcase
      return u;
   endfunction

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge CLK) begin
      if (!NRST) begin
         ctrl <= ctrl_t'(CTRL_RESET);
         red_map_fields <= RED_MAP_RESET;
         green_map_fields <= GREEN_MAP_RESET;
         blue_map_fields <= BLUE_MAP_RESET;
      end else if (REG_WR) begin
         case (REG_ADDR)
            ADDR_CTRL: ctrl <= ctrl_t'(REG_WDATA[5:0]);
            ADDR_RED_MAP: red_map_fields <= REG_WDATA;
            ADDR_GREEN_MAP: green_map_fields <= REG_WDATA;
            ADDR_BLUE_MAP: blue_map_fields <= REG_WDATA[15:0];
            default: ;
         endcase
      end
   end

   // A new underrun in the clearing cycle keeps the flag set.
   always_ff @(posedge CLK) begin
      if (!NRST) begin
         underrun <= 1'b0;
      end else if (underrun_evt) begin
         underrun <= 1'b1;
      end else if (REG_WR && REG_ADDR == ADDR_STATUS && REG_WDATA[STAT_UNDERRUN_BIT]) begin
         underrun <= 1'b0;
      end
   end

   always_comb begin
      rd_mux = 32'h00000000;
      case (REG_ADDR)
         ADDR_CTRL: rd_mux = {26'h0, ctrl};
         ADDR_RED_MAP: rd_mux = red_map_fields;
         ADDR_GREEN_MAP: rd_mux = green_map_fields;
         ADDR_BLUE_MAP: rd_mux = {16'h0000, blue_map_fields};
         ADDR_STATUS: begin
            rd_mux[STAT_FRAME_LSB +: 4] = frame_cnt;
            rd_mux[STAT_UNDERRUN_BIT] = underrun;
         end
         default: rd_mux = 32'h00000000;
      endcase
   end

   always_ff @(posedge CLK) begin
      if (!NRST) begin
         REG_RDATA <= 32'h00000000;
      end else begin
         REG_RDATA <= REG_RD ? rd_mux : 32'h00000000;
      end
   end

   // ------------------------------------------------------------
   // Pin synchronisers and frame counter
   // ------------------------------------------------------------
   always_ff @(posedge CLK) begin
      if (!NRST) begin
         sclk_sync <= 2'h0;
         fs_sync <= 2'h0;
         sclk_prev <= 1'b0;
         fs_prev <= 1'b0;
      end else begin
         sclk_sync <= {sclk_sync[0], SHIFT_CLK};
         fs_sync <= {fs_sync[0], FRAME_START};
         sclk_prev <= sclk_sync[1];
         fs_prev <= fs_sync[1];
      end
   end

   assign shift_edge = sclk_sync[1] & ~sclk_prev;
   assign frame_edge = fs_sync[1] & ~fs_prev;

   always_ff @(posedge CLK) begin
      if (!NRST) begin
         frame_cnt <= 4'h0;
      end else if (frame_edge) begin
         frame_cnt <= frame_cnt + 4'h1;
      end
   end

   // ------------------------------------------------------------
   // Lane accumulators
   // ------------------------------------------------------------
   assign dual = ctrl.scan == SCAN_DUAL4;
   assign lane_w = (ctrl.scan == SCAN_SINGLE8) ? W_WIDE : W_NARROW;
   assign enough = dual ? (cnt[0] >= W_NARROW && cnt[1] >= W_NARROW) : (cnt[0] >= lane_w);
   assign take = shift_edge & enough;
   assign underrun_evt = shift_edge & ~enough;

   for (genvar l = 0; l < 2; l++) begin : g_lane
      logic load;
      logic lane_take;
      logic [6:0] next_cnt;
      logic [63:0] next_acc;
      logic [31:0] w;
      assign w = WORD_IN[l].data;
      assign word_sw[l] = ctrl.byte_swap_select ? {w[7:0], w[15:8], w[23:16], w[31:24]} : w;
      always_comb unp[l] = unpack(word_sw[l], ctrl.mode, frame_cnt);
      assign load = WORD_IN[l].valid & lane_ready[l];
      assign lane_take = take & (l == 0 || dual);

      always_comb begin
         next_cnt = lane_take ? cnt[l] - lane_w : cnt[l];
         next_acc = lane_take ? acc[l] << lane_w : acc[l];
         if (load) begin
            next_acc = next_acc | ({unp[l].bits, 32'h00000000} >> next_cnt);
            next_cnt = next_cnt + unp[l].n;
         end
      end

      // Ready only while a whole word fits, so bits are never dropped.
      always_ff @(posedge CLK) begin
         if (!NRST) begin
            acc[l] <= 64'h0000000000000000;
            cnt[l] <= 7'h00;
            lane_ready[l] <= 1'b0;
         end else begin
            acc[l] <= next_acc;
            cnt[l] <= next_cnt;
            lane_ready[l] <= next_cnt <= LOAD_LIMIT && (l == 0 || dual);
         end
      end
   end

   assign WORD_READY = {lane_ready[1], lane_ready[0]};

   // ------------------------------------------------------------
   // Panel data lines
   // ------------------------------------------------------------
   // On underrun the lines go low rather than repeat stale pixels.
   always_ff @(posedge CLK) begin
      if (!NRST) begin
         PANEL_DATA_LINES <= 8'h00;
      end else if (take) begin
         unique case (ctrl.scan)
            SCAN_DUAL4: PANEL_DATA_LINES <= {acc[0][63:60], acc[1][63:60]};
            SCAN_SINGLE4: PANEL_DATA_LINES <= {4'h0, acc[0][63:60]};
            SCAN_SINGLE8: PANEL_DATA_LINES <= acc[0][63:56];
            default: PANEL_DATA_LINES <= 8'h00;
         endcase
      end else if (underrun_evt) begin
         PANEL_DATA_LINES <= 8'h00;
      end else if (ctrl.scan == SCAN_SINGLE4) begin
         PANEL_DATA_LINES[7:4] <= 4'h0;
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!NRST);

   a_mono_bypass: assert property (
      ctrl.mode == MODE_MONO |-> unp[0].bits == word_sw[0] && unp[0].n == N_MONO)
      else $error("Mono word not passed straight through.");

   a_gray_width: assert property (
      (ctrl.mode == MODE_GRAY4 |-> unp[0].n == 7'h10) and
      (ctrl.mode == MODE_GRAY16 |-> unp[0].n == 7'h08))
      else $error("Gray pixel count per word wrong.");

   a_color_width: assert property (ctrl.mode == MODE_COLOR256 |-> unp[0].n == 7'h0C)
      else $error("256-color word must yield 12 components.");

   a_full_level: assert property (
      ctrl.mode == MODE_GRAY16 && word_sw[0] == 32'hFFFFFFFF |-> unp[0].bits[31:24] == 8'hFF)
      else $error("Level 15 must always be on.");

   a_zero_level: assert property (
      ctrl.mode == MODE_GRAY16 && word_sw[0] == 32'h00000000 |-> unp[0].bits[31:24] == 8'h00)
      else $error("Level 0 must always be off.");

   a_gray_map: assert property (
      ctrl.mode == MODE_GRAY4 && word_sw[0][31:30] == 2'h2
      |-> unp[0].bits[31] == dith(blue_map_fields[11:8], frame_cnt))
      else $error("Gray code 2 not mapped through third blue field.");

   a_single4_high: assert property (
      ctrl.scan == SCAN_SINGLE4 && $past(ctrl.scan) == SCAN_SINGLE4
      && $past(ctrl.scan, 2) == SCAN_SINGLE4 |-> PANEL_DATA_LINES[7:4] == 4'h0)
      else $error("High data lines driven in 4-bit single scan.");

   a_wide_shift: assert property (
      take && ctrl.scan == SCAN_SINGLE8 |=> PANEL_DATA_LINES == $past(acc[0][63:56])
      ##0 cnt[0] <= ACC_BITS)
      else $error("8-bit shift did not present top accumulator byte.");

   a_dual_halves: assert property (
      take && dual |=> PANEL_DATA_LINES == {$past(acc[0][63:60]), $past(acc[1][63:60])})
      else $error("Dual scan halves not shifted together.");

   a_frame_step: assert property (
      frame_edge |=> frame_cnt == $past(frame_cnt) + 4'h1)
      else $error("Frame counter did not advance on frame start.");

   c_color_load: cover property (ctrl.mode == MODE_COLOR256 && WORD_IN[0].valid && lane_ready[0]);
   c_dual_take: cover property (take && dual);
   c_frame_wrap: cover property (frame_edge && frame_cnt == 4'hF);
   c_underrun: cover property (underrun_evt);

endmodule
`default_nettype wire

/* logic/stn_pixel_pkg.sv */
// Constants, types and register layout for the passive-matrix pixel pipeline.
// Assumes a single system clock domain; the panel shift clock is sampled as data.
package stn_pixel_pkg;

   // ------------------------------------------------------------
   // Register map (byte addresses) and field positions
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_RED_MAP = 8'h04;
   localparam logic [7:0] ADDR_GREEN_MAP = 8'h08;
   localparam logic [7:0] ADDR_BLUE_MAP = 8'h0C;
   localparam logic [7:0] ADDR_STATUS = 8'h10;
   localparam int STAT_FRAME_LSB = 0;
   localparam int STAT_UNDERRUN_BIT = 4;

   // ------------------------------------------------------------
   // Modes and carriers
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      MODE_MONO = 3'h0,
      MODE_GRAY4 = 3'h1,
      MODE_GRAY16 = 3'h2,
      MODE_COLOR256 = 3'h3,
      MODE_COLOR4096 = 3'h4
   } pixel_mode_t;

   typedef enum logic [1:0] {
      SCAN_DUAL4 = 2'h0,
      SCAN_SINGLE4 = 2'h1,
      SCAN_SINGLE8 = 2'h2
   } scan_type_t;

   typedef struct packed {
      logic byte_swap_select;
      scan_type_t scan;
      pixel_mode_t mode;
   } ctrl_t;

   typedef struct packed {
      logic valid;
      logic [31:0] data;
   } word_in_t;

   typedef struct packed {
      logic [6:0] n;
      logic [31:0] bits;
   } unpack_t;

   // ------------------------------------------------------------
   // Reset values and bit counts
   // ------------------------------------------------------------
   localparam logic [5:0] CTRL_RESET = 6'h00;
   localparam logic [31:0] RED_MAP_RESET = 32'h00000000;
   localparam logic [31:0] GREEN_MAP_RESET = 32'h00000000;
   localparam logic [15:0] BLUE_MAP_RESET = 16'h0000;
   localparam logic [6:0] ACC_BITS = 7'h40;
   localparam logic [6:0] LOAD_LIMIT = 7'h20;
   localparam logic [6:0] N_MONO = 7'h20;
   localparam logic [6:0] N_GRAY4 = 7'h10;
   localparam logic [6:0] N_NIBBLE = 7'h08;
   localparam logic [6:0] N_COLOR256 = 7'h0C;
   localparam logic [6:0] W_NARROW = 7'h04;
   localparam logic [6:0] W_WIDE = 7'h08;

   // Duty cycle num/den per intensity level 0..15.
   localparam logic [2:0] DUTY_NUM [16] = '{3'h0, 3'h1, 3'h1, 3'h1, 3'h1, 3'h2, 3'h3, 3'h1,
                                           3'h4, 3'h3, 3'h2, 3'h5, 3'h3, 3'h4, 3'h6, 3'h1};
   localparam logic [2:0] DUTY_DEN [16] = '{3'h1, 3'h7, 3'h5, 3'h4, 3'h3, 3'h5, 3'h7, 3'h2,
                                           3'h7, 3'h5, 3'h3, 3'h7, 3'h4, 3'h5, 3'h7, 3'h1};

endpackage

/* test/panel_column_driver.sv */
// Behavioural column driver of a passive-matrix panel: shift clock, frame pulse, data capture.
// Assumes the pipeline settles its data lines within one shift period after each rising edge.
`timescale 1ns/1ps
`default_nettype none
module panel_column_driver (
   // Panel pins
   output logic shift_clk,
   output logic frame_start,
   input wire logic [7:0] data_lines
);
   initial begin
      shift_clk = 1'b0;
      frame_start = 1'b0;
   end

   // ------------------------------------------------------------
   // Transfers
   // ------------------------------------------------------------
   // The shift clock stands low outside transfers. A real driver latches on the
   // following edge, so the data are taken just before that edge would come.
   task automatic shift_one(output logic [7:0] v);
      shift_clk <= 1'b1;
      #40;
      shift_clk <= 1'b0;
      #39;
      v = data_lines;
      #1;
   endtask

   task automatic frame_pulse();
      frame_start <= 1'b1;
      #40;
      frame_start <= 1'b0;
      #40;
   endtask
endmodule
`default_nettype wire

/* test/test_stn_lcd_pixel_pipeline.sv */
// Self-checking bench for the pixel pipeline: registers, unpacking, maps, dithering, scan types.
// Assumes the panel model steps the shift clock and frame pulse in 40 ns steps from CLK rising edges, in phase with CLK.
`timescale 1ns/1ps
`default_nettype none
module test_stn_lcd_pixel_pipeline
   import stn_pixel_pkg::*;
;
   localparam logic [31:0] red_tab = 32'hF0F0F00F;
   localparam logic [31:0] green_tab = 32'h0F0F0FF0;
   localparam logic [15:0] blue_tab = 16'h0F00;
   logic CLK = 1'b0;
   logic NRST = 1'b0;
   logic [7:0] REG_ADDR = 8'h00;
   logic [31:0] REG_WDATA = 32'h00000000;
   logic REG_WR = 1'b0;
   logic REG_RD = 1'b0;
   logic [31:0] REG_RDATA;
   word_in_t [1:0] WORD_IN = '0;
   logic [1:0] WORD_READY;
   logic SHIFT_CLK;
   logic FRAME_START;
   logic [7:0] PANEL_DATA_LINES;
   int bad_count = 0;
   int check_count = 0;
   int cycles = 0;

   stn_lcd_pixel_pipeline stn_lcd_pixel_pipeline_inst (
      .CLK(CLK), .NRST(NRST), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
      .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .WORD_IN(WORD_IN),
      .WORD_READY(WORD_READY), .SHIFT_CLK(SHIFT_CLK), .FRAME_START(FRAME_START),
      .PANEL_DATA_LINES(PANEL_DATA_LINES));
   panel_column_driver panel_column_driver_inst (
      .shift_clk(SHIFT_CLK), .frame_start(FRAME_START), .data_lines(PANEL_DATA_LINES));

   always #5 CLK = ~CLK;

   // A hang ends the run well past the few thousand cycles the tests need.
   always @(posedge CLK) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         bad_count++;
         end_of_test();
      end
   end

   // ------------------------------------------------------------
   // Access tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge CLK);
      REG_WR <= 1'b1;
      REG_ADDR <= a;
      REG_WDATA <= d;
      @(posedge CLK);
      REG_WR <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge CLK);
      REG_RD <= 1'b1;
      REG_ADDR <= a;
      @(posedge CLK);
      REG_RD <= 1'b0;
      #1 d = REG_RDATA;
   endtask

   // The word is held until ready is seen high at a sampling edge.
   task automatic put(input int l, input logic [31:0] d);
      int n = 0;
      @(posedge CLK);
      WORD_IN[l] <= {1'b1, d};
      @(negedge CLK);
      while (WORD_READY[l] !== 1'b1 && n < 50) begin
         n++;
         @(negedge CLK);
      end
      if (n >= 50) begin
         bad_count++;
      end
      @(posedge CLK);
      WORD_IN[l] <= '0;
   endtask

   task automatic sh(input logic [7:0] exp);
      logic [7:0] b;
      panel_column_driver_inst.shift_one(b);
      chk({24'h0, b}, {24'h0, exp});
   endtask

   function automatic logic [31:0] ctl(scan_type_t s, pixel_mode_t m, logic sw);
      return {26'h0, sw, s, m};
   endfunction

   // Map fields hold only 0 or 15, so the expected bit does not depend on the frame.
   function automatic logic [2:0] rgb(input logic [7:0] p);
      rgb[2] = red_tab[4*p[7:5] +: 4] == 4'hF;
      rgb[1] = green_tab[4*p[4:2] +: 4] == 4'hF;
      rgb[0] = blue_tab[4*p[1:0] +: 4] == 4'hF;
   endfunction

   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial begin
      logic [31:0] r;
      logic [63:0] px;
      logic [23:0] s;
      int q, n, d, f;
      f = 0;
      repeat (6) @(posedge CLK);
      NRST <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         rd(8'(i * 4), r);
         chk(r, 32'h0);
      end
      wr(ADDR_RED_MAP, red_tab);
      wr(ADDR_GREEN_MAP, green_tab);
      wr(ADDR_BLUE_MAP, 32'hFFFF0F00);
      rd(ADDR_BLUE_MAP, r);
      chk(r, 32'h00000F00);
      rd(ADDR_RED_MAP, r);
      chk(r, red_tab);
      wr(ADDR_CTRL, ctl(SCAN_SINGLE8, MODE_MONO, 1'b0));
      sh(8'h00);
      chk({30'h0, WORD_READY}, 32'h00000001);
      rd(ADDR_STATUS, r);
      chk(r & 32'h10, 32'h10);
      wr(ADDR_STATUS, 32'h10);
      rd(ADDR_STATUS, r);
      chk(r & 32'h10, 32'h0);
      put(0, 32'hA5C30F81);
      foreach (px[i]) px[i] = 1'b0;
      px[31:0] = 32'hA5C30F81;
      for (int i = 3; i >= 0; i--) sh(px[8*i +: 8]);
      wr(ADDR_CTRL, ctl(SCAN_SINGLE8, MODE_MONO, 1'b1));
      put(0, 32'h11223344);
      for (int i = 0; i < 4; i++) sh(8'h44 - 8'(i * 8'h11));
      wr(ADDR_CTRL, ctl(SCAN_SINGLE4, MODE_MONO, 1'b0));
      put(0, 32'h9A3CE512);
      for (int i = 7; i >= 0; i--) sh(8'(32'h9A3CE512 >> (4 * i)) & 8'h0F);
      wr(ADDR_CTRL, ctl(SCAN_DUAL4, MODE_MONO, 1'b0));
      put(0, 32'h12345678);
      put(1, 32'h9ABCDEF0);
      for (int i = 7; i >= 0; i--) begin
         sh({4'(32'h12345678 >> (4 * i)), 4'(32'h9ABCDEF0 >> (4 * i))});
      end
      wr(ADDR_CTRL, ctl(SCAN_SINGLE8, MODE_COLOR256, 1'b0));
      px = 64'h00FFA55A3C96E107;
      put(0, px[63:32]);
      put(0, px[31:0]);
      for (int i = 0; i < 8; i++) s[21 - 3 * i +: 3] = rgb(px[56 - 8 * i +: 8]);
      for (int i = 2; i >= 0; i--) sh(s[8*i +: 8]);
      wr(ADDR_CTRL, ctl(SCAN_SINGLE8, MODE_GRAY4, 1'b0));
      put(0, 32'h1B1B1B1B);
      sh(8'h22);
      sh(8'h22);
      wr(ADDR_CTRL, ctl(SCAN_SINGLE8, MODE_COLOR4096, 1'b0));
      put(0, 32'hF0F0F0F0);
      put(0, 32'h0FF00FF0);
      put(0, 32'hFFFF0000);
      sh(8'hAA);
      sh(8'h66);
      sh(8'hF0);
      wr(ADDR_CTRL, ctl(SCAN_SINGLE8, MODE_GRAY16, 1'b0));
      for (int l = 0; l < 16; l++) begin
         n = DUTY_NUM[l];
         d = DUTY_DEN[l];
         for (int k = 0; k < 16; k++) begin
            rd(ADDR_STATUS, r);
            chk(r, 32'(f % 16));
            q = (f % 16) % d;
            put(0, {8{4'(l)}});
            // On in a frame where the running count of on-frames steps up.
            sh((((q + 1) * n) / d != (q * n) / d) ? 8'hFF : 8'h00);
            panel_column_driver_inst.frame_pulse();
            f++;
         end
      end
      end_of_test();
   end
endmodule
`default_nettype wire
